// ---- logic/a429t_defs.svh ----
/*
 * Constants of the serial transmitter: clock rates, bit and gap timing,
 * queue sizes and word layout.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef A429T_DEFS_SVH
`define A429T_DEFS_SVH

`define A429T_CLK_PERIOD_NS  20
`define A429T_DATA_CLK_NS    1000
`define A429T_DIV            (`A429T_DATA_CLK_NS / `A429T_CLK_PERIOD_NS)
`define A429T_HS_HALF        5
`define A429T_HS_GAP         40
`define A429T_LS_HALF        40
`define A429T_LS_GAP         320
`define A429T_FIFO_DEPTH     32
`define A429T_HALF_LEVEL     16
`define A429T_WORD_BITS      32
`define A429T_HALF_BITS      16
`define A429T_PAR_BIT        31
`define A429T_SYNC_W         20

`endif

// ---- logic/a429t_pkg.sv ----
/*
 * Types of the serial transmitter.
 * Assumes a429t_defs.svh is on the include path.
 */
package a429t_pkg;
	`include "a429t_defs.svh"

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DATA,
		ST_NULL,
		ST_GAP
	} a429t_state_t;

	typedef logic [`A429T_WORD_BITS-1:0] a429t_word_t;
endpackage

// ---- logic/a429t_top.sv ----
/*
 * Serial transmitter with its word queue, loopback and repeater path.
 * Assumes one 50 MHz clock; control bits come from same-clock logic,
 * host pins and enable/reset pins are asynchronous.
 */
// How it works
// [R1] host loads low half, then high half
// [R2] parity on: store 31 bits, else 32
// [R3] 32 words max; full flag, loads ignored
// [R4] ready flag high when queue empty
// [R5] half flag high below 16 words
// [R6] parity bit: odd when select 0, even 1
// [R7] parity off: all 32 bits sent
// [R8] enable pops oldest word, bit quickly out
// [R9] high speed: 5 data, 5 null, 40 gap
// [R10] low speed: 40 data, 40 null, 320 gap
// [R11] loopback: rx1 true, rx2 inverted data
// [R12] serial pair always driven by transmitter
// [R13] receive side independent of transmit loads; a repeater read in the same cycle as a high-half load is ignored
// [R14] full receive queue overwrites last word; no receive queue here, the only queue is built with OVERWRITE 0
// [R15] repeater copies read word, low first
// [R16] outside repeater either half read first
// [R17] master reset stops, clears queue, flags
// [R18] master reset leaves control bits alone
// [R19] serial pair null while not sending
`include "a429t_defs.svh"

module a429t_fifo #(
	parameter int WIDTH     = `A429T_WORD_BITS,
	parameter int DEPTH     = `A429T_FIFO_DEPTH,
	parameter bit OVERWRITE = 1'b0
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             ce_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o,
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d, wa;
	logic [AW:0]      lvl_q, lvl_d;
	logic             full, we, push, pop;

	assign full        = lvl_q == (AW+1)'(DEPTH);
	assign in_ready_o  = !full || OVERWRITE;
	assign out_valid_o = lvl_q != '0;
	assign out_data_o  = mem_q[rd_q];
	assign level_o     = lvl_q;

	always_comb begin
		push  = in_valid_i && !full;
		pop   = out_valid_o && out_ready_i;
		we    = push || (in_valid_i && full && OVERWRITE); // see [R14]
		// overwrite hits the newest slot, never the one being read
		wa    = push ? wr_q : wr_q - AW'(1);
		wr_d  = push ? wr_q + AW'(1) : wr_q;
		rd_d  = pop ? rd_q + AW'(1) : rd_q;
		lvl_d = lvl_q + (AW+1)'(push) - (AW+1)'(pop);
		if (flush_i) begin
			wr_d  = '0;
			rd_d  = '0;
			lvl_d = '0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			lvl_q <= '0;
		end else if (ce_i) begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			lvl_q <= lvl_d;
		end
	end

	// storage needs no reset; level gates every read
	always_ff @(posedge clk_i) begin
		if (ce_i && we && !flush_i) begin
			mem_q[wa] <= in_data_i;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	full_refuse_a: assert property ( // see [R3]
		ce_i && full && in_valid_i && !OVERWRITE
		&& !out_ready_i && !flush_i |=> lvl_q == $past(lvl_q))
		else $error("load into full queue changed its level");
	level_bound_a: assert property (lvl_q <= (AW+1)'(DEPTH)) // see [R3]
		else $error("queue level above depth");
endmodule // a429t_fifo

module a429t_top
	import a429t_pkg::*;
#(
	parameter int DEPTH = `A429T_FIFO_DEPTH,
	parameter int DIV   = `A429T_DIV
) (
	input  wire logic        CLOCK_I,
	input  wire logic        RST_N_I,
	input  wire logic        CLK_EN_I,
	input  wire logic        MASTER_RESET_IN_I,
	input  wire logic [15:0] DATA_I,
	input  wire logic        LOAD_LOW_HALF_STROBE_N_I,
	input  wire logic        LOAD_HIGH_HALF_STROBE_N_I,
	input  wire logic        TRANSMIT_ENABLE_IN_I,
	input  wire logic        HIGH_SPEED_I,
	input  wire logic        PARITY_ENABLE_I,
	input  wire logic        PARITY_POLARITY_SELECT_I,
	input  wire logic        LOOPBACK_DISABLE_N_I,
	input  wire logic        REPEAT_MODE_I,
	input  wire logic        RX_READ_I,
	input  wire logic        RX_READ_SEL_I,
	input  wire logic [31:0] RX_WORD_I,
	output logic [1:0]       SERIAL_OUT_PAIR_O,
	output logic [1:0]       LOOP_RX1_O,
	output logic [1:0]       LOOP_RX2_O,
	output logic             TX_READY_O,
	output logic             TX_FULL_FLAG_O,
	output logic             TX_HALF_FULL_FLAG_O,
	output logic             LOAD_READY_O
);
	if (DIV < 1 || DEPTH < 2 * `A429T_HALF_LEVEL) begin : g_bad_par
		$error("divider or queue depth out of range");
	end

	logic [1:0]               rst_q;
	logic                     rst_n;
	logic [`A429T_SYNC_W-1:0] s1_q, s2_q, s3_q;
	logic                     mr, ent, lo_rise, hi_rise;
	logic [15:0]              data_s;

	// strobes and data share one sync path, so data is steady at the edge
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_q <= '0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			// strobes idle high, so no false rising edge after reset
			s1_q <= {4'hC, 16'h0000};
			s2_q <= {4'hC, 16'h0000};
			s3_q <= {4'hC, 16'h0000};
		end else if (CLK_EN_I) begin
			s1_q <= {LOAD_LOW_HALF_STROBE_N_I, LOAD_HIGH_HALF_STROBE_N_I,
				MASTER_RESET_IN_I, TRANSMIT_ENABLE_IN_I, DATA_I};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign lo_rise = s2_q[19] && !s3_q[19];
	assign hi_rise = s2_q[18] && !s3_q[18];
	assign mr      = s2_q[17];
	assign ent     = s2_q[16];
	assign data_s  = s2_q[15:0];

	// host load and repeater assembly
	logic [15:0]       low_q, low_d, rep_q, rep_d;
	logic              rep_ok_q, rep_ok_d, push;
	a429t_word_t       push_word, fifo_word;
	logic              fifo_ready, fifo_valid, pop;
	logic [$clog2(DEPTH):0] level;

	always_comb begin
		low_d     = lo_rise ? data_s : low_q; // see [R1]
		rep_d     = rep_q;
		rep_ok_d  = rep_ok_q;
		push      = 1'b0;
		push_word = {data_s, low_q};
		if (hi_rise) begin
			push = 1'b1; // see [R1]
		end else if (RX_READ_I && REPEAT_MODE_I) begin
			// repeater: low half captured, high half completes the copy
			if (!RX_READ_SEL_I) begin
				rep_d    = RX_WORD_I[15:0]; // see [R15]
				rep_ok_d = 1'b1;
			end else if (rep_ok_q) begin
				push      = 1'b1; // see [R15]
				push_word = {RX_WORD_I[31:16], rep_q};
				rep_ok_d  = 1'b0;
			end
		end
		// outside repeater mode receive reads never touch this path
		if (!REPEAT_MODE_I || mr) begin
			rep_ok_d = 1'b0; // see [R16] [R13]
		end
		if (PARITY_ENABLE_I) begin
			push_word[`A429T_PAR_BIT] = 1'b0; // see [R2]
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			low_q    <= '0;
			rep_q    <= '0;
			rep_ok_q <= 1'b0;
		end else if (CLK_EN_I) begin
			low_q    <= low_d;
			rep_q    <= rep_d;
			rep_ok_q <= rep_ok_d;
		end
	end

	a429t_fifo #(
		.WIDTH     (`A429T_WORD_BITS),
		.DEPTH     (DEPTH),
		.OVERWRITE (1'b0)
	) u_fifo (
		.clk_i       (CLOCK_I),
		.rst_n_i     (rst_n),
		.ce_i        (CLK_EN_I),
		.flush_i     (mr),
		.in_valid_i  (push && !mr),
		.in_ready_o  (fifo_ready),
		.in_data_i   (push_word),
		.out_valid_o (fifo_valid),
		.out_ready_i (pop),
		.out_data_o  (fifo_word),
		.level_o     (level)
	);
	assign LOAD_READY_O = fifo_ready; // see [R3]

	// serializer
	a429t_state_t state_q, state_d;
	a429t_word_t  sh_q, sh_d;
	logic [4:0]   bit_q, bit_d;
	logic [8:0]   cnt_q, cnt_d, half_n, gap_n;
	logic [15:0]  div_q, div_d;
	logic [1:0]   ser_q, ser_d, lb1_q, lb1_d, lb2_q, lb2_d;
	logic         tick, rdy_q, rdy_d, full_q, full_d, hf_q, hf_d;

	assign half_n = HIGH_SPEED_I ? 9'(`A429T_HS_HALF) : 9'(`A429T_LS_HALF);
	assign gap_n  = HIGH_SPEED_I ? 9'(`A429T_HS_GAP) : 9'(`A429T_LS_GAP);
	assign tick   = div_q == 16'(DIV - 1);

	always_comb begin
		state_d = state_q;
		sh_d    = sh_q;
		bit_d   = bit_q;
		cnt_d   = cnt_q;
		div_d   = tick ? 16'h0000 : div_q + 16'h0001;
		pop     = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (ent && fifo_valid) begin
					pop     = 1'b1; // see [R8]
					sh_d    = fifo_word; // see [R7]
					if (PARITY_ENABLE_I) begin
						sh_d[`A429T_PAR_BIT] = ^fifo_word[30:0] ^
							!PARITY_POLARITY_SELECT_I; // see [R6]
					end
					bit_d   = '0;
					cnt_d   = '0;
					div_d   = '0; // bit timing starts at the pop
					state_d = ST_DATA;
				end
			end
			ST_DATA: begin
				if (tick) begin
					cnt_d = cnt_q + 9'h001;
					// speed may change mid-word; never count past the end
					if (cnt_d >= half_n) begin
						cnt_d   = '0;
						state_d = ST_NULL; // see [R9] [R10]
					end
				end
			end
			ST_NULL: begin
				if (tick) begin
					cnt_d = cnt_q + 9'h001;
					if (cnt_d >= half_n) begin
						cnt_d = '0;
						sh_d  = sh_q >> 1;
						bit_d = bit_q + 5'h01;
						state_d = (bit_q == 5'h1F) ? ST_GAP : ST_DATA;
					end
				end
			end
			ST_GAP: begin
				if (tick) begin
					cnt_d = cnt_q + 9'h001;
					if (cnt_d >= gap_n) begin
						state_d = ST_IDLE; // see [R9] [R10]
					end
				end
			end
			default: state_d = ST_IDLE;
		endcase
		if (mr) begin
			state_d = ST_IDLE; // see [R17]
			pop     = 1'b0;
		end
		// null whenever no bit is on the line
		ser_d  = (state_d == ST_DATA) ? (sh_d[0] ? 2'b10 : 2'b01)
			: 2'b00; // see [R19] [R12]
		lb1_d  = LOOPBACK_DISABLE_N_I ? 2'b00 : ser_d; // see [R11]
		lb2_d  = LOOPBACK_DISABLE_N_I ? 2'b00 : {ser_d[0], ser_d[1]};
		// flags follow the level; control inputs are never cleared here
		rdy_d  = mr || level == '0; // see [R4] [R18]
		full_d = !mr && level == ($clog2(DEPTH)+1)'(DEPTH); // see [R3]
		hf_d   = mr || level < ($clog2(DEPTH)+1)'(`A429T_HALF_LEVEL); // see [R5]
	end

	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			sh_q    <= '0;
			bit_q   <= '0;
			cnt_q   <= '0;
			div_q   <= '0;
			ser_q   <= 2'b00;
			lb1_q   <= 2'b00;
			lb2_q   <= 2'b00;
			rdy_q   <= 1'b1;
			full_q  <= 1'b0;
			hf_q    <= 1'b1;
		end else if (CLK_EN_I) begin
			state_q <= state_d;
			sh_q    <= sh_d;
			bit_q   <= bit_d;
			cnt_q   <= cnt_d;
			div_q   <= div_d;
			ser_q   <= ser_d;
			lb1_q   <= lb1_d;
			lb2_q   <= lb2_d;
			rdy_q   <= rdy_d;
			full_q  <= full_d;
			hf_q    <= hf_d;
		end
	end

	assign SERIAL_OUT_PAIR_O   = ser_q;
	assign LOOP_RX1_O          = lb1_q;
	assign LOOP_RX2_O          = lb2_q;
	assign TX_READY_O          = rdy_q;
	assign TX_FULL_FLAG_O      = full_q;
	assign TX_HALF_FULL_FLAG_O = hf_q;

	// helper: cycles the line has held a data level
	logic [15:0] run_q;
	always_ff @(posedge CLOCK_I or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= '0;
		end else if (CLK_EN_I) begin
			run_q <= (ser_q != 2'b00) ? run_q + 16'h0001 : 16'h0000;
		end
	end

	default clocking tcb @(posedge CLOCK_I); endclocking
	default disable iff (!rst_n || !CLK_EN_I);

	store_31_a: assert property ( // see [R2]
		push && PARITY_ENABLE_I |-> !push_word[`A429T_PAR_BIT])
		else $error("parity slot stored as data");
	pop_start_a: assert property (pop |=> ser_q != 2'b00) // see [R8]
		else $error("first bit not on line after pop");
	parity_gen_a: assert property ( // see [R6]
		pop && PARITY_ENABLE_I
		|=> (^sh_q) == !$past(PARITY_POLARITY_SELECT_I))
		else $error("generated parity wrong");
	raw_word_a: assert property ( // see [R7]
		pop && !PARITY_ENABLE_I |=> sh_q == $past(fifo_word))
		else $error("unparitied word altered");
	// a level cut short by master reset is not a timing fault
	bit_width_a: assert property ( // see [R9] [R10]
		$fell(ser_q != 2'b00) && !$past(mr)
		|-> $past(run_q) + 16'h0001 == 16'($past(half_n)) * 16'(DIV))
		else $error("data level width wrong");
	null_idle_a: assert property ( // see [R19]
		state_q inside {ST_IDLE, ST_GAP, ST_NULL} |-> ser_q == 2'b00)
		else $error("line not null outside data phase");
	loop_copy_a: assert property ( // see [R11]
		!LOOPBACK_DISABLE_N_I ##1 !$stable(ser_q)
		|-> LOOP_RX1_O == ser_q && LOOP_RX2_O == {ser_q[0], ser_q[1]})
		else $error("loopback does not follow line");
	half_flag_a: assert property ( // see [R5]
		##1 hf_q == ($past(mr) ||
		$past(level) < ($clog2(DEPTH)+1)'(`A429T_HALF_LEVEL)))
		else $error("half flag wrong");
	ready_flag_a: assert property (level != '0 && !mr |=> !rdy_q) // see [R4]
		else $error("ready flag high with words queued");
	mr_clear_a: assert property ( // see [R17]
		mr |=> state_q == ST_IDLE && level == '0 && ser_q == 2'b00)
		else $error("master reset did not clear");

	word_sent_c: cover property (state_q == ST_GAP ##1 state_q == ST_IDLE);
	full_c: cover property (full_q && push);
	repeat_c: cover property (push && REPEAT_MODE_I && !hi_rise);
	mr_busy_c: cover property (mr && state_q == ST_DATA);
endmodule // a429t_top

// ---- tb/a429t_line_rx.sv ----
/*
 * Far-side model: a line receiver that decodes the serial pair
 * into words and measures level and gap lengths in clock cycles.
 * Assumes the pair is sampled on the design's clock.
 */
module a429t_line_rx (
	input  wire logic        clk_i,
	input  wire logic [1:0]  pair_i,
	output logic [31:0]      word_o,
	output int               words_o,
	output int               gap_o,
	output int               level_len_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0]  prev;
	logic [31:0] shreg;
	int          nbits;
	int          nulls;
	int          run;

	initial begin
		words_o = 0;
		nbits = 0;
		nulls = 0;
		run = 0;
		prev = 2'h0;
		gap_o = 0;
		level_len_o = 0;
		word_o = 32'h0;
		shreg = 32'h0;
	end

	// a new bit starts on each null-to-level change; one line means 1
	always @(posedge clk_i) begin
		if (pair_i != 2'h0) begin
			run++;
			if (prev == 2'h0) begin
				if (nbits == 0)
					gap_o = nulls;
				shreg = {pair_i[1], shreg[31:1]};
				nbits++;
			end
			nulls = 0;
		end else begin
			if (prev != 2'h0) begin
				level_len_o = run;
				if (nbits == 32) begin
					word_o = shreg;
					words_o++;
					nbits = 0;
				end
			end
			run = 0;
			nulls++;
		end
		prev = pair_i;
	end
endmodule // a429t_line_rx

// ---- tb/test_a429t_top.sv ----
/*
 * Self-checking bench for the serial transmitter.
 * Assumes the design package and the line receiver model.
 */
module test_a429t_top;
	timeunit 1ns;
	timeprecision 1ns;
	import a429t_pkg::*;
	localparam int DIV = 2;
	logic        clk, rst_n, mr, lo_n, hi_n, en, hs, pen, psel, lb_n;
	logic        rep, rd, sel;
	logic [15:0] data;
	logic [31:0] rxw, w0, w1;
	logic [1:0]  pair, l1, l2;
	logic        ready, full, half, ldr;
	logic [31:0] word, q [32];
	int          words, gap, len, n;
	int          miscompares = 0;
	int          checks_done = 0;

	a429t_top #(.DEPTH(32), .DIV(DIV)) i_a429t_top (
		.CLOCK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1),
		.MASTER_RESET_IN_I(mr), .DATA_I(data),
		.LOAD_LOW_HALF_STROBE_N_I(lo_n), .LOAD_HIGH_HALF_STROBE_N_I(hi_n),
		.TRANSMIT_ENABLE_IN_I(en), .HIGH_SPEED_I(hs),
		.PARITY_ENABLE_I(pen), .PARITY_POLARITY_SELECT_I(psel),
		.LOOPBACK_DISABLE_N_I(lb_n), .REPEAT_MODE_I(rep), .RX_READ_I(rd),
		.RX_READ_SEL_I(sel), .RX_WORD_I(rxw), .SERIAL_OUT_PAIR_O(pair),
		.LOOP_RX1_O(l1), .LOOP_RX2_O(l2), .TX_READY_O(ready),
		.TX_FULL_FLAG_O(full), .TX_HALF_FULL_FLAG_O(half),
		.LOAD_READY_O(ldr));

	a429t_line_rx i_a429t_line_rx (.clk_i(clk), .pair_i(pair),
		.word_o(word), .words_o(words), .gap_o(gap), .level_len_o(len));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// strobes held 3 cycles, data held past the synchronisers
	task automatic load(input logic [31:0] w);
		@(posedge clk);
		data <= w[15:0];
		lo_n <= 1'b0;
		tick(3);
		lo_n <= 1'b1;
		tick(3);
		data <= w[31:16];
		hi_n <= 1'b0;
		tick(3);
		hi_n <= 1'b1;
		tick(8);
	endtask

	task automatic wait_words(input int t);
		for (int i = 0; i < 20000 && words < t; i++)
			@(posedge clk);
		check(words, t);
	endtask

	function automatic logic [31:0] expw(logic [31:0] w, logic e, logic s);
		return e ? {^w[30:0] ^ ~s, w[30:0]} : w;
	endfunction

	initial begin
		{rst_n, mr, en, hs, pen, psel, rep, rd, sel} = 9'h0;
		{lo_n, hi_n, lb_n} = 3'h7;
		data = 16'h0;
		rxw = 32'h0;
		void'($urandom(32'hECE2));
		tick(10);
		rst_n <= 1'b1;
		tick(6);
		check({ready, full, half, ldr, pair}, 32'h2C);
		$display("reset test done");
		for (int k = 0; k < 4; k++) begin
			{pen, psel, lb_n, hs} <= {k[1], k[0], k[0], 1'b1};
			w0 = $urandom;
			w1 = $urandom;
			n = words;
			load(w0);
			load(w1);
			check(ready, 0);
			en <= 1'b1;
			for (int i = 0; i < 3000 && pair == 2'h0; i++)
				@(posedge clk);
			tick(3);
			check({l1, l2}, k[0] ? 4'h0 : {pair, pair[0], pair[1]});
			check(pair != 2'h0, 1);
			wait_words(n + 1);
			check(word, expw(w0, k[1], k[0]));
			wait_words(n + 2);
			check(word, expw(w1, k[1], k[0]));
			check(len, 5 * DIV);
			check(gap >= 45 * DIV && gap <= 45 * DIV + 4, 1);
			tick(20);
			check({ready, pair}, 3'h4);
			en <= 1'b0;
		end
		$display("parity and loopback test done");
		hs <= 1'b0;
		pen <= 1'b1;
		w0 = $urandom;
		load(w0);
		en <= 1'b1;
		wait_words(words + 1);
		check(word, expw(w0, 1'b1, psel));
		check(len, 40 * DIV);
		en <= 1'b0;
		hs <= 1'b1;
		pen <= 1'b0;
		$display("low speed test done");
		for (int i = 1; i <= 33; i++) begin
			w0 = $urandom;
			if (i <= 32)
				q[i-1] = w0;
			load(w0);
			if (i == 15)
				check(half, 1);
			if (i == 16)
				check(half, 0);
			if (i >= 32)
				check({full, ldr}, 2'h2);
		end
		n = words;
		en <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			wait_words(n + i + 1);
			check(word, q[i]);
		end
		tick(100);
		check(words, n + 32);
		check(ready, 1'b1);
		en <= 1'b0;
		$display("fill test done");
		rep <= 1'b1;
		w0 = $urandom;
		{rd, sel, rxw} <= {2'h3, $urandom};
		tick(1);
		{rd, sel, rxw} <= {2'h2, w0};
		tick(1);
		rd <= 1'b0;
		tick(2);
		{rd, sel} <= 2'h3;
		tick(1);
		{rd, rep} <= 2'h0;
		tick(8);
		en <= 1'b1;
		wait_words(n + 33);
		check(word, w0);
		tick(100);
		check(words, n + 33);
		$display("repeater test done");
		load($urandom);
		load($urandom);
		for (int i = 0; i < 3000 && pair == 2'h0; i++)
			@(posedge clk);
		tick(30);
		mr <= 1'b1;
		tick(6);
		check({ready, full, half, pair}, 5'h14);
		mr <= 1'b0;
		tick(1500);
		check(words, n + 33);
		check(pair, 2'h0);
		$display("master reset test done");
		tally_and_finish;
	end

	// the run needs about 40k cycles
	initial begin
		tick(90000);
		miscompares++;
		tally_and_finish;
	end
endmodule // test_a429t_top
